// file: edpc_core.v
// Energy-detect power management with Avalon-MM register access.
`timescale 1ns/1ps
`include "edpc_map.vh"
module edpc_core #(
  // Cycles of silence on the data input before both counters clear; shortened in simulation.
  parameter IDLE_CYCLES = `EDPC_IDLE_TIMEOUT_S * `EDPC_CLK_HZ
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Line energy inputs from the analog front end
  input wire line_data_event,
  input wire line_error_event,
  input wire line_energy,
  // Line driver control
  output reg line_driver_power_up,
  output wire line_pulse,
  // Interrupt
  output wire irq
);
  // Idle count width covers the two-second default with room.
  localparam CW = 32;
  // Bus handshake states: each request spends one cycle waiting, then one answering.
  localparam BUS_IDLE = 1'h0;
  localparam BUS_ACK = 1'h1;


  // Pin synchronisers; stage one feeds only stage two.
  reg [2:0] sync1_r;
  reg [2:0] sync2_r;
  reg data_prev_r;
  reg err_prev_r;

  // Control register fields.
  reg en_r;
  reg auto_up_r;
  reg auto_down_r;
  reg man_r;
  reg burst_dis_r;
  reg err_met_r;
  reg data_met_r;
  reg [3:0] err_thr_r;
  reg [3:0] data_thr_r;

  // Counters and state.
  reg [3:0] data_cnt_r;
  reg [3:0] err_cnt_r;
  reg [CW-1:0] idle_cnt_r;
  reg power_up_start_r;

  // Interrupt registers.
  reg [`EDPC_IRQ_BITS-1:0] irq_stat_r;
  reg [`EDPC_IRQ_BITS-1:0] irq_mask_r;

  // Bus answer handshake: one wait cycle then acknowledge.
  reg ack_r;
  reg ack_nxt;

  wire data_evt;
  wire err_evt;
  wire energy;
  wire access;
  wire wr_ack;
  wire rd_ack;
  wire ctrl_wr;
  wire ctrl_rd;
  wire data_reached;
  wire err_reached;
  wire go_up;
  wire go_down;
  wire idle_expired;
  // Bus decode, threshold hits and next power state.
  wire sel_ctrl;
  wire sel_stat;
  wire sel_mask;
  wire err_hit;
  wire data_hit;
  reg power_nxt;
  reg start_nxt;

  // Saturating increment used by both event counters.
  function [3:0] sat_inc;
    input [3:0] v;
    begin
      sat_inc = (v == 4'hf) ? v : v + 4'h1;
    end
  endfunction

  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      data_prev_r <= 1'b0;
      err_prev_r <= 1'b0;
    end
    else
    begin
      sync1_r <= {line_energy, line_error_event, line_data_event};
      sync2_r <= sync1_r;
      data_prev_r <= sync2_r[0];
      err_prev_r <= sync2_r[1];
    end
  end

  assign data_evt = sync2_r[0] & ~data_prev_r;
  assign err_evt = sync2_r[1] & ~err_prev_r;
  assign energy = sync2_r[2];

  // Request is held until waitrequest falls, so the access completes at the ack cycle.
  assign access = (avs_read | avs_write) & ~ack_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_ack = avs_write & ack_r;
  assign rd_ack = avs_read & ack_r;
  assign ctrl_wr = wr_ack && sel_ctrl;
  assign ctrl_rd = rd_ack && sel_ctrl;

  // One decode per register serves the writes and the read-clear; the read mux decodes the address in its own case.
  assign sel_ctrl = (avs_address == `EDPC_ADDR_CTRL);
  assign sel_stat = (avs_address == `EDPC_ADDR_IRQ_STAT);
  assign sel_mask = (avs_address == `EDPC_ADDR_IRQ_MASK);

  // A request still up after its answer is taken as a new one and waits again.
  always @*
  begin
    case (ack_r)
      BUS_IDLE:
        ack_nxt = (avs_read | avs_write) ? BUS_ACK : BUS_IDLE;
      BUS_ACK:
        ack_nxt = BUS_IDLE;
      default:
        ack_nxt = BUS_IDLE;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (reset)
      ack_r <= BUS_IDLE;
    else
      ack_r <= ack_nxt;
  end

  assign data_reached = sat_inc(data_cnt_r) >= data_thr_r;
  assign err_reached = sat_inc(err_cnt_r) >= err_thr_r;
  assign idle_expired = idle_cnt_r >= IDLE_CYCLES - 1;

  // Automatic transitions; the manual toggle overrides both.
  assign go_up = en_r && !line_driver_power_up && auto_up_r && data_evt && data_reached;
  assign go_down = en_r && line_driver_power_up && auto_down_r && !energy;

  // Hits count only while enabled, so a disabled block raises no flag.
  assign err_hit = en_r && err_evt && err_reached;
  assign data_hit = en_r && data_evt && data_reached;

  // Next power state; the manual toggle wins over both automatic paths.
  always @*
  begin
    power_nxt = line_driver_power_up;
    start_nxt = 1'b0;
    if (man_r && en_r)
    begin
      power_nxt = !line_driver_power_up;
      start_nxt = !line_driver_power_up;
    end
    else if (go_up)
    begin
      power_nxt = 1'b1;
      start_nxt = 1'b1;
    end
    else if (go_down)
      power_nxt = 1'b0;
  end

  // Event counters and idle timer.
  // Only a data event restarts the timer; error events alone let the counts expire.
  always @(posedge clk_sys)
  begin
    if (reset || !en_r)
    begin
      data_cnt_r <= 4'h0;
      err_cnt_r <= 4'h0;
      idle_cnt_r <= {CW{1'b0}};
    end
    else if (data_evt)
    begin
      data_cnt_r <= sat_inc(data_cnt_r);
      if (err_evt)
        err_cnt_r <= sat_inc(err_cnt_r);
      idle_cnt_r <= {CW{1'b0}};
    end
    else if (idle_expired)
    begin
      data_cnt_r <= 4'h0;
      err_cnt_r <= 4'h0;
      idle_cnt_r <= {CW{1'b0}};
    end
    else
    begin
      if (err_evt)
        err_cnt_r <= sat_inc(err_cnt_r);
      idle_cnt_r <= idle_cnt_r + 32'h1;
    end
  end

  // Control register and power state.
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      en_r <= 1'b0;
      auto_up_r <= `EDPC_RST_AUTO;
      auto_down_r <= `EDPC_RST_AUTO;
      man_r <= 1'b0;
      burst_dis_r <= 1'b0;
      err_thr_r <= `EDPC_RST_THRESH;
      data_thr_r <= `EDPC_RST_THRESH;
      err_met_r <= 1'b0;
      data_met_r <= 1'b0;
      line_driver_power_up <= 1'b0;
      power_up_start_r <= 1'b0;
    end
    else
    begin
      power_up_start_r <= 1'b0;
      if (ctrl_wr)
      begin
        en_r <= avs_writedata[`EDPC_BIT_EN];
        auto_up_r <= avs_writedata[`EDPC_BIT_AUTO_UP];
        auto_down_r <= avs_writedata[`EDPC_BIT_AUTO_DOWN];
        man_r <= avs_writedata[`EDPC_BIT_MAN];
        burst_dis_r <= avs_writedata[`EDPC_BIT_BURST_DIS];
        err_thr_r <= avs_writedata[`EDPC_ERR_HI:`EDPC_ERR_LO];
        data_thr_r <= avs_writedata[`EDPC_DATA_HI:`EDPC_DATA_LO];
      end
      else
        man_r <= 1'b0;
      // A read clears the flags, but an event in the same cycle wins.
      if (ctrl_rd)
      begin
        err_met_r <= 1'b0;
        data_met_r <= 1'b0;
      end
      if (err_hit)
        err_met_r <= 1'b1;
      if (data_hit)
        data_met_r <= 1'b1;
      line_driver_power_up <= power_nxt;
      power_up_start_r <= start_nxt;
    end
  end

  // The burst length is taken at the power-up edge; changing bit 11 mid-burst has no effect.
  edpc_pulse_gen #(
    .GAP(`EDPC_PULSE_GAP)
  ) u_pulse (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(power_up_start_r),
    .count(burst_dis_r ? `EDPC_SINGLE_PULSE : `EDPC_BURST_PULSES),
    .pulse_out(line_pulse)
  );

  // Interrupt status: power-up, power-down, data met, error met.
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      irq_stat_r <= {`EDPC_IRQ_BITS{1'b0}};
      irq_mask_r <= {`EDPC_IRQ_BITS{1'b0}};
    end
    else
    begin
      if (wr_ack && sel_mask)
        irq_mask_r <= avs_writedata[`EDPC_IRQ_BITS-1:0];
      irq_stat_r <= (irq_stat_r & ~((wr_ack && sel_stat) ?
                    avs_writedata[`EDPC_IRQ_BITS-1:0] : {`EDPC_IRQ_BITS{1'b0}}))
                    | {err_hit, data_hit,
                       power_down_evt(line_driver_power_up, man_r, en_r, go_down, go_up),
                       power_up_start_r};
    end
  end

  // Any transition that leaves the driver powered down.
  function power_down_evt;
    input up;
    input man;
    input en;
    input down;
    input upgo;
    begin
      power_down_evt = up && ((man && en) || (!(man && en) && !upgo && down));
    end
  endfunction

  // Masking hides a status bit from the interrupt but leaves it pending.
  assign irq = |(irq_stat_r & irq_mask_r);

  // Read data is registered and valid at the ack edge.
  // The flags are captured here one edge before the read clears them, so a flag set at that capture edge is cleared unread.
  always @(posedge clk_sys)
  begin
    if (reset)
      avs_readdata <= 32'h0;
    else if (access && avs_read)
    begin
      case (avs_address)
        `EDPC_ADDR_CTRL:
          avs_readdata <= {16'h0, en_r, auto_up_r, auto_down_r, man_r, burst_dis_r,
                           line_driver_power_up, err_met_r, data_met_r, err_thr_r, data_thr_r};
        `EDPC_ADDR_IRQ_STAT:
          avs_readdata <= {28'h0, irq_stat_r};
        `EDPC_ADDR_IRQ_MASK:
          avs_readdata <= {28'h0, irq_mask_r};
        default:
          avs_readdata <= 32'h0;
      endcase
    end
  end
endmodule // edpc_core

// file: edpc_core_properties.sv
// Concurrent checks on the ports of the energy-detect power control.
`timescale 1ns/1ps
module edpc_core_properties (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Register bus
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Line side
  input wire line_driver_power_up,
  input wire line_pulse,
  input wire irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence req_start;
    $rose(avs_read || avs_write);
  endsequence
  sequence rd_done;
    avs_read && !avs_waitrequest;
  endsequence
  sequence man_done;
    avs_write && !avs_waitrequest && avs_address == 8'h1d && avs_writedata[15] && avs_writedata[12];
  endsequence
  bus_wait_once_a: assert property (req_start |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("request not answered after exactly one wait");
  bus_wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  man_toggle_a: assert property (man_done |-> ##2 line_driver_power_up != $past(line_driver_power_up, 2))
    else $error("manual write did not toggle power state");
  pulse_gap_a: assert property (line_pulse |=> !line_pulse [*8])
    else $error("line pulses too close together");
  pulse_start_a: assert property ($rose(line_driver_power_up) |-> ##[1:3] line_pulse)
    else $error("no pulse after power-up");
  power_read_a: assert property (rd_done ##0 avs_address == 8'h1d |-> avs_readdata[10] == $past(line_driver_power_up))
    else $error("power state bit differs from driver output");
  upper_zero_a: assert property (rd_done ##0 avs_address == 8'h1d |-> avs_readdata[31:16] == 16'h0)
    else $error("upper half of control read not zero");
  unmapped_zero_a: assert property (rd_done ##0 avs_address < 8'h1d |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  irq_reset_a: assert property ($fell(reset) |-> !irq)
    else $error("interrupt high after reset");
endmodule // edpc_core_properties

bind edpc_core edpc_core_properties chk (.clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .line_driver_power_up, .line_pulse, .irq);

// file: edpc_core_tb_top.sv
// Self-checking bench for the energy-detect power control.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; $display("Error %0t: got %h want %h", $time, a, e); end end
module edpc_core_tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, line_data_event, line_error_event, line_energy, line_driver_power_up, line_pulse, irq;
  int fail_count = 0;
  int checked = 0;
  int p0;
  always #5 clk_sys = ~clk_sys;
  edpc_core #(.IDLE_CYCLES(50)) dut (.clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .line_data_event, .line_error_event, .line_energy,
    .line_driver_power_up, .line_pulse, .irq);
  edpc_line_model model (.clk_sys, .line_pulse, .line_data_event, .line_error_event, .line_energy);
  task automatic results;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    q = 32'h0;
    // The answer is judged at the rising edge itself, where the write lands and read data stands.
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20)
    begin
      fail_count++;
      $display("Error %0t: bus timeout", $time);
    end
    else
      q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, {16'h0, d}, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, {16'h0, e})
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rc(8'h1d, 16'h6011);
    rc(8'h00, 16'h0000);
    wr(8'h02, 16'hffff);
    rc(8'h1d, 16'h6011);
    wr(8'h1f, 16'h000f);
    wr(8'h1d, 16'he011);
    p0 = model.pulse_cnt;
    model.events(1'b0, 1);
    idle(100);
    rc(8'h1d, 16'he511);
    `CHK(model.pulse_cnt - p0, 4)
    rc(8'h1d, 16'he411);
    `CHK(irq, 1'b1)
    rc(8'h1e, 16'h0005);
    wr(8'h1e, 16'h000f);
    rc(8'h1e, 16'h0000);
    `CHK(irq, 1'b0)
    // Error threshold of two with data threshold out of reach: only the error flag may rise.
    wr(8'h1d, 16'he02f);
    model.events(1'b0, 1);
    model.events(1'b1, 2);
    idle(10);
    rc(8'h1d, 16'he62f);
    rc(8'h1d, 16'he42f);
    wr(8'h1f, 16'h0000);
    idle(1);
    `CHK(irq, 1'b0)
    wr(8'h1f, 16'h000f);
    idle(1);
    `CHK(irq, 1'b1)
    wr(8'h1e, 16'h000f);
    model.line_energy <= 1'b0;
    idle(10);
    rc(8'h1d, 16'he02f);
    rc(8'h1e, 16'h0002);
    wr(8'h1e, 16'h000f);
    p0 = model.pulse_cnt;
    wr(8'h1d, 16'h9811);
    idle(30);
    rc(8'h1d, 16'h8c11);
    `CHK(model.pulse_cnt - p0, 1)
    wr(8'h1d, 16'h9011);
    idle(5);
    rc(8'h1d, 16'h8011);
    wr(8'h1d, 16'h8012);
    wr(8'h1e, 16'h000f);
    model.events(1'b0, 1);
    idle(80);
    model.events(1'b0, 1);
    idle(5);
    rc(8'h1d, 16'h8012);
    model.events(1'b0, 1);
    idle(5);
    rc(8'h1d, 16'h8112);
    wr(8'h1e, 16'h000f);
    wr(8'h1d, 16'h1011);
    model.events(1'b0, 1);
    model.events(1'b1, 1);
    idle(5);
    rc(8'h1d, 16'h0011);
    `CHK(irq, 1'b0)
    results();
  end
endmodule // edpc_core_tb_top

// file: edpc_line_model.sv
// Line-side model: event and energy levels toward the block, pulse counter from it.
`timescale 1ns/1ps
module edpc_line_model (
  // Clock
  input wire clk_sys,
  // From the block
  input wire line_pulse,
  // Toward the block
  output logic line_data_event,
  output logic line_error_event,
  output logic line_energy
);
  int pulse_cnt = 0;
  logic pulse_d = 1'b0;
  initial
  begin
    line_data_event = 1'b0;
    line_error_event = 1'b0;
    line_energy = 1'b1;
  end
  always @(posedge clk_sys)
  begin
    pulse_d <= line_pulse;
    if (line_pulse && !pulse_d) pulse_cnt <= pulse_cnt + 1;
  end
  // Events are held three cycles so the block's two-flop sync catches them whatever the phase.
  task automatic events(input bit err, input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      if (err) line_error_event <= 1'b1;
      else line_data_event <= 1'b1;
      repeat (3) @(posedge clk_sys);
      line_error_event <= 1'b0;
      line_data_event <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
endmodule // edpc_line_model

// file: edpc_map.vh
// Register map, field positions, reset values and timing constants for the energy-detect power control.
`ifndef EDPC_MAP_VH
`define EDPC_MAP_VH
`define EDPC_ADDR_CTRL 8'h1d
`define EDPC_ADDR_IRQ_STAT 8'h1e
`define EDPC_ADDR_IRQ_MASK 8'h1f
`define EDPC_BIT_EN 15
`define EDPC_BIT_AUTO_UP 14
`define EDPC_BIT_AUTO_DOWN 13
`define EDPC_BIT_MAN 12
`define EDPC_BIT_BURST_DIS 11
`define EDPC_BIT_PWR 10
`define EDPC_BIT_ERR_MET 9
`define EDPC_BIT_DATA_MET 8
`define EDPC_ERR_HI 7
`define EDPC_ERR_LO 4
`define EDPC_DATA_HI 3
`define EDPC_DATA_LO 0
`define EDPC_RST_AUTO 1'h1
`define EDPC_RST_THRESH 4'h1
`define EDPC_BURST_PULSES 3'h4
`define EDPC_SINGLE_PULSE 3'h1
`define EDPC_IDLE_TIMEOUT_S 2
`define EDPC_CLK_HZ 100000000
`define EDPC_IRQ_BITS 4
`define EDPC_IRQ_UP 0
`define EDPC_IRQ_DOWN 1
`define EDPC_IRQ_DATA 2
`define EDPC_IRQ_ERR 3
`define EDPC_PULSE_GAP 8'h10
`endif

// file: edpc_pulse_gen.v
// Energy-detect pulse burst generator fired on each line driver power-up.
`timescale 1ns/1ps
module edpc_pulse_gen #(
  parameter GAP = 8'h10
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Control
  input wire start,
  input wire [2:0] count,
  // Line side
  output reg pulse_out
);
  reg [2:0] left_r;
  reg [7:0] gap_r;

  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      left_r <= 3'h0;
      gap_r <= 8'h00;
      pulse_out <= 1'b0;
    end
    else if (start)
    begin
      // A new power-up restarts the burst rather than queueing a second one.
      left_r <= count;
      gap_r <= 8'h00;
      pulse_out <= 1'b0;
    end
    else if (gap_r != 8'h00)
    begin
      gap_r <= gap_r - 8'h01;
      pulse_out <= 1'b0;
    end
    else if (left_r != 3'h0)
    begin
      left_r <= left_r - 3'h1;
      gap_r <= GAP;
      pulse_out <= 1'b1;
    end
    else
    begin
      pulse_out <= 1'b0;
    end
  end
endmodule // edpc_pulse_gen
